//--- rtl/ltc_linearize_path.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ltc_linearize_path
    import ltc_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
)
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [23:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [23:0]             reg_rdata,
    input  wire logic signed [12:0] comp_sample,
    input  wire logic               diag_ov,
    input  wire logic               diag_uv,
    input  wire logic               diag_bist,
    input  wire logic               diag_range,
    input  wire logic               diag_coil,
    output logic [11:0]             enc_data,
    output logic                    enc_valid,
    output logic                    err_code_req,
    output logic                    out_hiz
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // counter is 12 bits and the pipeline needs four cycles per update
    if (TICK < 4 || TICK > 4096)
    begin : g_bad_tick
        $error("TICK out of range 4..4096");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N_POINTS-1:0][11:0] xtab;
        logic [3:0]                ctrl;
        logic [11:0]               gain;
        logic [11:0]               offs;
        logic [11:0]               clamph;
        logic [11:0]               clampl;
        logic [5:0]                cfg;
        logic [11:0]               tick_cnt;
        logic [2:0]                stg;
        logic signed [12:0]        curve_y;
        logic signed [11:0]        trim_y;
        logic [11:0]               result;
        logic [23:0]               rdata;
        logic                      err_code;
        logic                      hiz;
    } ltc_state_type;

    ltc_state_type      st;
    ltc_state_type      next_st;
    logic signed [12:0] curve_now;
    logic signed [24:0] prod;
    logic signed [15:0] trim_sum;
    logic [12:0]        y5;
    logic [12:0]        upper;
    logic [4:0]         diag_hit;
    logic               err_any;

    // ------------------------------------------------------------
    // curve stage
    // ------------------------------------------------------------
    ltc_curve u_curve
    (
        .sample   (comp_sample),
        .xtab     (st.xtab),
        .table_en (st.ctrl[BIT_TAB_EN]),
        .bin_mode (st.ctrl[BIT_BIN]),
        .in_inv   (st.ctrl[BIT_IN_INV]),
        .out_inv  (st.ctrl[BIT_OUT_INV]),
        .curve_y  (curve_now)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // read data valid only in the cycle after the strobe
        next_st.rdata = 24'h000000;
        // per-source diagnostic enables
        // worked out first, the status read below needs it this pass
        diag_hit = {diag_coil & st.cfg[CFG_COIL],
                    diag_range & st.cfg[CFG_RANGE],
                    diag_bist & st.cfg[CFG_BIST],
                    diag_uv & st.cfg[CFG_UV],
                    diag_ov & st.cfg[CFG_OV]};
        err_any = |diag_hit;
        // register writes
        if (reg_wr)
        begin
            if (reg_addr == OFS_CLAMP)
            begin
                next_st.clamph = reg_wdata[LO_LSB +: 12];
                next_st.clampl = reg_wdata[HI_LSB +: 12];
            end
            for (int i = 0; i < N_LIN_PAIR; i++)
            begin
                if (reg_addr == OFS_LIN0 + 8'(i))
                begin
                    next_st.xtab[2*i]   = reg_wdata[LO_LSB +: 12];
                    next_st.xtab[2*i+1] = reg_wdata[HI_LSB +: 12];
                end
            end
            if (reg_addr == OFS_LIN8)
            begin
                next_st.xtab[N_POINTS-1] = reg_wdata[LO_LSB +: 12];
                next_st.ctrl             = reg_wdata[CTRL_LSB +: 4];
            end
            if (reg_addr == OFS_TRIM)
            begin
                next_st.gain = reg_wdata[LO_LSB +: 12];
                next_st.offs = reg_wdata[HI_LSB +: 12];
            end
            if (reg_addr == OFS_CFG)
                next_st.cfg = reg_wdata[5:0];
        end
        // register reads; unmapped offsets read zero
        if (reg_rd)
        begin
            if (reg_addr == OFS_CLAMP)
                next_st.rdata = {st.clampl, st.clamph};
            for (int i = 0; i < N_LIN_PAIR; i++)
            begin
                if (reg_addr == OFS_LIN0 + 8'(i))
                    next_st.rdata = {st.xtab[2*i+1], st.xtab[2*i]};
            end
            if (reg_addr == OFS_LIN8)
                next_st.rdata = {8'h00, st.ctrl, st.xtab[N_POINTS-1]};
            if (reg_addr == OFS_TRIM)
                next_st.rdata = {st.offs, st.gain};
            if (reg_addr == OFS_CFG)
                next_st.rdata = {18'h00000, st.cfg};
            if (reg_addr == OFS_STATUS)
                next_st.rdata = {7'h00, diag_hit, st.result};
        end

        // update divider at the output rate
        if (st.tick_cnt == 12'(TICK - 1))
            next_st.tick_cnt = 12'h000;
        else
            next_st.tick_cnt = st.tick_cnt + 12'h001;
        // one pass through each stage per update
        next_st.stg = {st.stg[1:0], st.tick_cnt == 12'(TICK - 1)};
        if (st.tick_cnt == 12'(TICK - 1))
            next_st.curve_y = curve_now;

        // y times one plus gain, plus offset
        prod     = st.curve_y * $signed(st.gain);
        trim_sum = 16'(st.curve_y) + 16'(prod >>> GAIN_FRAC) + 16'($signed(st.offs));
        if (st.stg[0])
        begin
            // saturate into the signed 12-bit output range
            if (trim_sum > 16'(TRIM_MAX))
                next_st.trim_y = 12'(TRIM_MAX);
            else if (trim_sum < 16'(TRIM_MIN))
                next_st.trim_y = 12'(TRIM_MIN);
            else
                next_st.trim_y = 12'(trim_sum);
        end

        y5 = 13'(16'(st.trim_y) + 16'(U_OFFSET));
        upper = 13'(CLAMP_TOP) - {1'b0, st.clamph};
        if (st.stg[1])
        begin
            // clamp; lower field used as is
            // a crossed pair yields the upper limit when y5 exceeds it, else the lower limit
            if (y5 > upper)
                next_st.result = 12'(upper);
            else if (y5 < {1'b0, st.clampl})
                next_st.result = st.clampl;
            else
                next_st.result = y5[11:0];
        end

        // error code by default, high impedance as option
        next_st.err_code = err_any && !st.cfg[CFG_HIZ];
        next_st.hiz      = err_any && st.cfg[CFG_HIZ];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.xtab     <= '0;
            st.ctrl     <= RST_CTRL;
            st.gain     <= RST_FIELD;
            st.offs     <= RST_FIELD;
            st.clamph   <= RST_FIELD;
            st.clampl   <= RST_FIELD;
            st.cfg      <= RST_CFG;
            st.tick_cnt <= 12'h000;
            st.stg      <= 3'h0;
            st.curve_y  <= 13'h0000;
            st.trim_y   <= 12'h000;
            st.result   <= 12'h000;
            st.rdata    <= 24'h000000;
            st.err_code <= 1'b0;
            st.hiz      <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata    = st.rdata;
    assign enc_data     = st.result;
    assign enc_valid    = st.stg[2];
    assign err_code_req = st.err_code;
    assign out_hiz      = st.hiz;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // cycles since the previous hand-over, saturating; starts saturated
    // so the first hand-over after reset is not timed
    logic [12:0] gap;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            gap <= 13'h1FFF;
        else if (enc_valid)
            gap <= 13'h0000;
        else if (gap != 13'h1FFF)
            gap <= gap + 13'h0001;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tick;
        st.tick_cnt == 12'(TICK - 1);
    endsequence
    sequence s_trim_done;
        ##2 st.stg[1];
    endsequence

    property p_rate;
        enc_valid && $past(enc_valid, 1) == 1'b0 && gap != 13'h1FFF |-> gap == 13'(TICK - 1);
    endproperty
    a_rate: assert property (p_rate) else $error("update spacing wrong");

    property p_pipe;
        s_tick |-> ##3 enc_valid;
    endproperty
    a_pipe: assert property (p_pipe) else $error("hand-over not 3 cycles after tick");

    // limits as they stood at the clamp edge; a write may land just after
    property p_upper;
        st.stg[1] && {1'b0, st.clampl} <= upper |=> {1'b0, enc_data} <= $past(upper);
    endproperty
    a_upper: assert property (p_upper) else $error("result above upper limit");

    property p_lower;
        st.stg[1] && {1'b0, st.clampl} <= upper |=> enc_data >= $past(st.clampl);
    endproperty
    a_lower: assert property (p_lower) else $error("result below lower limit");

    property p_pass;
        st.stg[1] && y5 <= upper && y5 >= {1'b0, st.clampl} |=> enc_data == $past(y5[11:0]);
    endproperty
    a_pass: assert property (p_pass) else $error("in-range sample altered");

    property p_unity;
        s_tick ##1 (st.gain == 12'h000 && st.offs == 12'h000 && st.curve_y <= 13'(TRIM_MAX)
            && st.curve_y >= 13'(TRIM_MIN)) |=> st.trim_y == 12'($past(st.curve_y));
    endproperty
    a_unity: assert property (p_unity) else $error("unity trim changed sample");

    property p_bypass;
        s_tick and !st.ctrl[BIT_TAB_EN] |=> st.curve_y == $past(comp_sample);
    endproperty
    a_bypass: assert property (p_bypass) else $error("disabled table altered sample");

    property p_bin;
        st.ctrl[BIT_TAB_EN] && st.ctrl[BIT_BIN] && !st.ctrl[BIT_OUT_INV]
            |-> curve_now[7:0] == 8'h00 && curve_now <= 13'(Y_LAST)
                && curve_now >= 13'(Y_EXT_MIN);
    endproperty
    a_bin: assert property (p_bin) else $error("bin output not a step value");

    property p_span;
        st.ctrl[BIT_TAB_EN] |-> curve_now <= 13'(Y_EXT_MAX) && curve_now >= 13'(Y_EXT_MIN);
    endproperty
    a_span: assert property (p_span) else $error("curve output beyond extrapolation");

    property p_diag;
        ##1 (out_hiz || err_code_req) |-> $past(err_any) && (out_hiz == $past(st.cfg[CFG_HIZ]));
    endproperty
    a_diag: assert property (p_diag) else $error("error output without enabled cause");

    property p_enable;
        !(diag_ov & st.cfg[CFG_OV]) && !(diag_uv & st.cfg[CFG_UV]) && !(diag_bist & st.cfg[CFG_BIST])
            && !(diag_range & st.cfg[CFG_RANGE]) && !(diag_coil & st.cfg[CFG_COIL])
            |=> !out_hiz && !err_code_req;
    endproperty
    a_enable: assert property (p_enable) else $error("disabled source reported");

    property p_trim_follow;
        s_tick |-> s_trim_done;
    endproperty
    a_trim_follow: assert property (p_trim_follow) else $error("clamp stage skipped");

    // hand-over value only moves on the clamp edge
    property p_hold;
        !st.stg[1] |=> $stable(enc_data);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved between updates");

    // code mode reports the error and keeps the pin driven
    property p_code;
        err_any && !st.cfg[CFG_HIZ] |=> err_code_req && !out_hiz;
    endproperty
    a_code: assert property (p_code) else $error("code mode not reported");

    // high-impedance mode replaces the error code
    property p_hiz;
        err_any && st.cfg[CFG_HIZ] |=> out_hiz && !err_code_req;
    endproperty
    a_hiz: assert property (p_hiz) else $error("high impedance mode not reported");

    // open limits leave only the sign-bit flip of the offset conversion
    property p_offset;
        st.stg[1] && st.clamph == 12'h000 && st.clampl == 12'h000
            |=> enc_data == ($past(st.trim_y) ^ 12'h800);
    endproperty
    a_offset: assert property (p_offset) else $error("unsigned conversion wrong");
endmodule
`default_nettype wire

//--- rtl/ltc_pkg.sv
package ltc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int UPDATE_HZ   = 16_000;
    localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CLAMP  = 8'h08;
    localparam logic [7:0] OFS_LIN0   = 8'h0A;
    localparam logic [7:0] OFS_LIN8   = 8'h12;
    localparam logic [7:0] OFS_TRIM   = 8'h13;
    localparam logic [7:0] OFS_CFG    = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h15;
    localparam int         N_LIN_PAIR = 8;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LO_LSB      = 0;
    localparam int HI_LSB      = 12;
    localparam int CTRL_LSB    = 12;
    localparam int BIT_TAB_EN  = 0;
    localparam int BIT_BIN     = 1;
    localparam int BIT_OUT_INV = 2;
    localparam int BIT_IN_INV  = 3;
    localparam int CFG_OV      = 0;
    localparam int CFG_UV      = 1;
    localparam int CFG_BIST    = 2;
    localparam int CFG_RANGE   = 3;
    localparam int CFG_COIL    = 4;
    localparam int CFG_HIZ     = 5;
    localparam int STAT_DIAG   = 12;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [11:0] RST_FIELD = 12'h000;
    localparam logic [3:0]  RST_CTRL  = 4'h0;
    localparam logic [5:0]  RST_CFG   = 6'h1F;
    // ------------------------------------------------------------
    // curve and output arithmetic
    // ------------------------------------------------------------
    localparam int N_POINTS  = 17;
    localparam int Y_FIRST   = -2048;
    localparam int Y_STEP    = 256;
    localparam int Y_LAST    = 2048;
    localparam int Y_EXT_MIN = -2304;
    localparam int Y_EXT_MAX = 2304;
    localparam int GAIN_FRAC = 11;
    localparam int TRIM_MIN  = -2048;
    localparam int TRIM_MAX  = 2047;
    localparam int U_OFFSET  = 2048;
    localparam int CLAMP_TOP = 4096;
endpackage

//--- rtl/ltc_curve.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_curve
    import ltc_pkg::*;
(
    input  wire logic signed [12:0]        sample,
    input  wire logic [N_POINTS-1:0][11:0] xtab,
    input  wire logic                      table_en,
    input  wire logic                      bin_mode,
    input  wire logic                      in_inv,
    input  wire logic                      out_inv,
    output logic signed [12:0]             curve_y
);
    logic signed [13:0] s;
    logic [4:0]         cnt;
    logic signed [23:0] base;
    logic signed [23:0] den;
    logic signed [23:0] ya;
    logic signed [23:0] q;
    logic signed [23:0] y;

    // ------------------------------------------------------------
    // threshold count and segment pick
    // ------------------------------------------------------------
    always_comb
    begin
        s = in_inv ? -14'(sample) : 14'(sample);
        cnt = 5'd0;
        for (int i = 0; i < N_POINTS; i++)
        begin
            if (14'($signed(xtab[i])) <= s)
                cnt = cnt + 5'd1;
        end
        // segment ends; below x0 and above x16 reuse the end segments
        if (cnt == 5'd0)
        begin
            base = 24'($signed(xtab[0]));
            den  = 24'($signed(xtab[1])) - base;
            ya   = 24'(Y_FIRST);
        end
        else if (cnt == 5'(N_POINTS))
        begin
            base = 24'($signed(xtab[N_POINTS-1]));
            den  = base - 24'($signed(xtab[N_POINTS-2]));
            ya   = 24'(Y_LAST);
        end
        else
        begin
            base = 24'($signed(xtab[cnt - 5'd1]));
            den  = 24'($signed(xtab[cnt])) - base;
            ya   = 24'(Y_FIRST) + 24'(Y_STEP) * 24'(cnt - 5'd1);
        end
        // zero span only occurs in the end segments; hold the end point
        q = (den == 24'sd0) ? 24'sd0 : ((24'(s) - base) * 24'(Y_STEP)) / den;
        if (!table_en)
            y = 24'(sample);
        else if (bin_mode)
            y = (cnt == 5'd0) ? 24'(Y_EXT_MIN) : ya;
        else
        begin
            y = ya + q;
            if (y < 24'(Y_EXT_MIN))
                y = 24'(Y_EXT_MIN);
            else if (y > 24'(Y_EXT_MAX))
                y = 24'(Y_EXT_MAX);
        end
        curve_y = (table_en && out_inv) ? -13'(y) : 13'(y);
    end
endmodule
`default_nettype wire

//--- testbench/ltc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_partner
    import ltc_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic signed [12:0] want,
    input  wire logic [11:0]        enc_data,
    input  wire logic               enc_valid,
    output logic signed [12:0]      comp_sample,
    output logic [11:0]             seen,
    output logic [15:0]             cnt
);
    // ----------------------------------------
    // upstream stage and output encoder
    // ----------------------------------------
    // new sample only right after an update, so a tick never sees it move
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comp_sample <= '0;
            seen        <= '0;
            cnt         <= '0;
        end
        else if (enc_valid)
        begin
            comp_sample <= want;
            seen        <= enc_data;
            cnt         <= cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
    import ltc_pkg::*;
    logic               core_clk;
    logic               rst_n;
    logic [7:0]         reg_addr;
    logic [23:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [23:0]        reg_rdata;
    logic signed [12:0] comp_sample;
    logic signed [12:0] want;
    logic [4:0]         diag;
    logic [11:0]        enc_data;
    logic               enc_valid;
    logic               err_code_req;
    logic               out_hiz;
    logic [11:0]        seen;
    logic [15:0]        cnt;
    logic [23:0]        d;
    int                 failures;
    int                 comparisons;
    int                 gap = 0;
    int                 xs [17];
    int                 i;
    int                 up;
    int                 cl;
    // short tick keeps the run brief
    ltc_linearize_path #(.TICK(8)) ltc_linearize_path_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_sample(comp_sample),
        .diag_ov(diag[0]), .diag_uv(diag[1]), .diag_bist(diag[2]), .diag_range(diag[3]),
        .diag_coil(diag[4]), .enc_data(enc_data), .enc_valid(enc_valid),
        .err_code_req(err_code_req), .out_hiz(out_hiz));
    ltc_partner ltc_partner_i (
        .core_clk(core_clk), .rst_n(rst_n), .want(want), .enc_data(enc_data),
        .enc_valid(enc_valid), .comp_sample(comp_sample), .seen(seen), .cnt(cnt));
    // ----------------------------------------
    // reference arithmetic
    // ----------------------------------------
    function automatic logic [11:0] model(int s, logic [3:0] c, int g, int o, int ch, int cl);
        int y;
        int t;
        int k;
        t = c[3] ? -s : s;
        y = s;
        if (c[0] && c[1])
        begin
            y = -2304;
            for (k = 0; k < 17; k++) if (xs[k] <= t) y = -2048 + 256 * k;
        end
        else if (c[0])
            y = (2 * t > 2304) ? 2304 : (2 * t < -2304) ? -2304 : 2 * t;
        if (c[0] && c[2]) y = -y;
        t = y + ((y * g) >>> 11) + o;
        t = (t > 2047) ? 2047 : (t < -2048) ? -2048 : t;
        t = t + 2048;
        if (t > 4096 - ch) t = 4096 - ch;
        else if (t < cl) t = cl;
        return t[11:0];
    endfunction
    // ----------------------------------------
    // bus master and closing
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic complete_run;
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // program table, trim and clamp, then check two updates later
    task automatic run_case(int s, logic [3:0] c, int g, int o, int ch, int cl);
        int k;
        int n;
        xs[0] = c[1] ? -2048 + int'($urandom % 1024) : -1024;
        for (k = 1; k < 17; k++)
            xs[k] = xs[k-1] + (!c[1] ? 128 : ($urandom % 4 == 0) ? 0 : int'($urandom % 180));
        wr(8'h08, {cl[11:0], ch[11:0]});
        for (k = 0; k < 8; k++) wr(8'(8'h0A + k), {xs[2*k+1][11:0], xs[2*k][11:0]});
        wr(8'h12, {8'h00, c, xs[16][11:0]});
        wr(8'h13, {o[11:0], g[11:0]});
        // sample changes at an edge; count from the next one so no update is missed
        want <= s[12:0];
        @(posedge core_clk);
        n = cnt;
        k = 0;
        while (cnt < n + 2 && k < 100)
        begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 100)
            failures++;
        `CHK("enc_data", model(s, c, g, o, ch, cl), seen)
        rd(8'h12, d);
        `CHK("ctrl_reg", {8'h00, c, xs[16][11:0]}, d)
        rd(8'h15, d);
        `CHK("status_result", model(s, c, g, o, ch, cl), d[11:0])
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // cycles between updates, fixed rate
    always @(posedge core_clk)
        if (enc_valid)
        begin
            if (gap != 0) `CHK("update_gap", 8, gap)
            gap <= 1;
        end
        else if (gap != 0)
            gap <= gap + 1;
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        diag = 5'h00;
        want = '0;
        failures = 0;
        comparisons = 0;
        void'($urandom(32'h2322));
        repeat (8) @(posedge core_clk);
        `CHK("valid_in_reset", 1'b0, enc_valid)
        rst_n <= 1'b1;
        rd(8'h08, d);
        `CHK("clamp_reset", 24'h000000, d)
        rd(8'h14, d);
        `CHK("cfg_reset", 24'h00001F, d)
        rd(8'h20, d);
        `CHK("unmapped", 24'h000000, d)
        // corner cases: pass-through, saturation, both clamps, bin ends, extrapolation
        run_case(100, 4'h0, 0, 0, 0, 0);
        run_case(4095, 4'h0, 0, 0, 0, 0);
        run_case(2000, 4'h0, 0, 0, 1000, 0);
        run_case(-1000, 4'h0, 0, 0, 0, 1500);
        run_case(-4095, 4'h3, 0, 0, 0, 0);
        run_case(4095, 4'h3, 0, 0, 0, 0);
        run_case(2000, 4'h1, -1024, 0, 0, 0);
        run_case(-2000, 4'h1, 0, 300, 0, 0);
        run_case(700, 4'hB, 2047, -5, 0, 0);
        run_case(-333, 4'h7, -2048, 17, 0, 0);
        for (i = 0; i < 60; i++)
        begin
            cl = $urandom % 3000;
            up = cl + int'($urandom % (4097 - cl));
            run_case(int'($urandom % 8191) - 4095, 4'($urandom) | 4'h1,
                     int'($urandom % 4096) - 2048, int'($urandom % 4096) - 2048,
                     (4096 - up) % 4096, cl);
        end
        for (i = 0; i < 5; i++)
        begin
            wr(8'h14, 24'h00001F);
            diag <= 5'(1 << i);
            repeat (2) @(posedge core_clk);
            #1 `CHK("err_code", 1'b1, err_code_req)
            rd(8'h15, d);
            `CHK("status_diag", 5'(1 << i), d[16:12])
            wr(8'h14, 24'h00001F & ~(24'h000001 << i));
            repeat (2) @(posedge core_clk);
            #1 `CHK("err_masked", 1'b0, err_code_req)
            wr(8'h14, 24'h00003F);
            repeat (2) @(posedge core_clk);
            #1 `CHK("hiz_mode", 2'b10, {out_hiz, err_code_req})
            diag <= 5'h00;
        end
        wr(8'h15, 24'hFFFFFF);
        rd(8'h15, d);
        `CHK("status_ro", {5'h00, seen}, d[16:0])
        complete_run();
    end
endmodule
`default_nettype wire
